// ### verification/fchp_host_model.sv
// Purpose: host processor model driving the control port pins
// Assumes: pins change on the falling clock edge
// Notes: a released data wire shows the inverse of its last level
`default_nettype none
module fchp_host_model
    import fchp_pkg::*;
(
    // Clock
    input wire logic core_clk_in,
    // Host pins
    output fchp_pkg::fchp_addr_type addr_out,
    output fchp_pkg::fchp_strobe_type strobe_out,
    output fchp_pkg::fchp_word_type bus_out,
    // Device drive
    input wire fchp_pkg::fchp_word_type dev_data_in,
    input wire logic dev_oe_in
);
    timeunit 1ns;
    timeprecision 1ns;
    fchp_word_type drv;
    fchp_word_type last;
    logic drv_en;
    // Nobody driving: no stale value may pass for read data
    assign bus_out = dev_oe_in ? dev_data_in : drv_en ? drv : ~last;
    always @(posedge core_clk_in)
    begin
        last <= bus_out;
    end
    initial
    begin
        addr_out = '0;
        strobe_out = 3'b111;
        drv = '0;
        drv_en = 1'b0;
        last = '0;
    end
    task automatic xfer(input fchp_addr_type a, input fchp_word_type d,
        input logic wr, input logic leg, output fchp_word_type q);
        @(negedge core_clk_in);
        addr_out = a;
        drv = d;
        drv_en = wr;
        strobe_out.output_enable_n = !leg;
        if (leg)
            strobe_out.write_strobe_n = !wr;
        else
            strobe_out.chip_select_n = 1'b0;
        @(negedge core_clk_in);
        if (leg)
            strobe_out.chip_select_n = 1'b0;
        else if (wr)
            strobe_out.write_strobe_n = 1'b0;
        else
            strobe_out.output_enable_n = 1'b0;
        // Taken at a falling edge, well after the registered data settled
        repeat (5) @(negedge core_clk_in);
        q = bus_out;
        @(negedge core_clk_in);
        strobe_out.chip_select_n = leg ? 1'b1 : 1'b0;
        strobe_out.write_strobe_n = 1'b1;
        if (!leg)
            strobe_out.output_enable_n = 1'b1;
        @(negedge core_clk_in);
        // Data held until the strobe is gone
        strobe_out.chip_select_n = 1'b1;
        drv_en = 1'b0;
        repeat (3) @(negedge core_clk_in);
    endtask
endmodule // fchp_host_model
`default_nettype wire

// ### verification/fchp_host_port_tb.sv
// Purpose: self-checking bench of the host control port
// Assumes: seed 37, inputs driven on the falling edge
// Notes: expectations come from shadow arrays kept by the bench
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
 $display("[ERR] %0t got %h want %h", $time, (g), (e)); end end
module filter_chip_host_control_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fchp_pkg::*;
    logic core_clk_in, rst_in, snap_write_in, host_data_oe_out;
    logic single_pulse_out, sync_out_pin_out, coef_path_b_out;
    logic [7:0] snap_index_in;
    fchp_addr_type host_addr_in;
    fchp_strobe_type host_strobe_in;
    fchp_word_type host_data_in, host_data_out, snap_data_in, rd;
    fchp_word_type [12:0] ctrl_regs_out;
    fchp_word_type exp_ctrl [13];
    fchp_word_type exp_coef [128];
    fchp_word_type exp_snap [256];
    int miscompares, compares, pulse_hi, sync_lo, a;
    fchp_host_port #(.CTRL_COUNT(13)) DUT (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .host_addr_in(host_addr_in),
        .host_strobe_in(host_strobe_in), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe_out(host_data_oe_out),
        .snap_write_in(snap_write_in), .snap_index_in(snap_index_in),
        .snap_data_in(snap_data_in), .ctrl_regs_out(ctrl_regs_out),
        .single_pulse_out(single_pulse_out),
        .sync_out_pin_out(sync_out_pin_out),
        .coef_path_b_out(coef_path_b_out));
    fchp_host_model HOST (.core_clk_in(core_clk_in), .addr_out(host_addr_in),
        .strobe_out(host_strobe_in), .bus_out(host_data_in),
        .dev_data_in(host_data_out), .dev_oe_in(host_data_oe_out));
    initial
    begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    function automatic fchp_word_type expect_word(int x);
        if (x <= 12)
            return exp_ctrl[x];
        if (x < 128)
            return 16'h0000;
        if (x < 256)
            return exp_coef[x - 128];
        return exp_snap[x - 256];
    endfunction
    function automatic logic coin();
        return 1'($urandom);
    endfunction
    task automatic acc(int x, fchp_word_type d, logic wr, logic leg);
        HOST.xfer(9'(x), d, wr, leg, rd);
        if (wr && x <= 12 && x != 11)
            exp_ctrl[x] = d;
        if (wr && x >= 128 && x < 256)
            exp_coef[x - 128] = d;
        if (!wr && x != 11)
            `CHK(rd, expect_word(x))
        if (x >= 128 && x < 256)
            `CHK(coef_path_b_out, 1'(((x - 128) >> 2) >= 16))
    endtask
    task automatic chk_ctrl();
        for (int i = 0; i < 13; i++)
            `CHK(ctrl_regs_out[i], exp_ctrl[i])
    endtask
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Bus drive must follow the raw strobes in every cycle after reset
    always @(posedge core_clk_in)
    begin
        if (!rst_in)
            `CHK(host_data_oe_out, !host_strobe_in.chip_select_n &&
                !host_strobe_in.output_enable_n &&
                host_strobe_in.write_strobe_n)
    end
    // Registered outputs are counted away from the edge that launches them
    always @(negedge core_clk_in)
    begin
        if (single_pulse_out === 1'b1)
            pulse_hi++;
        if (sync_out_pin_out === 1'b0)
            sync_lo++;
    end
    initial
    begin
        #1_000_000;
        miscompares++;
        stop_test();
    end
    initial
    begin
        rst_in = 1'b1;
        snap_write_in = 1'b0;
        snap_index_in = '0;
        snap_data_in = '0;
        miscompares = 0;
        compares = 0;
        foreach (exp_ctrl[i])
            exp_ctrl[i] = '0;
        void'($urandom(37));
        repeat (8) @(negedge core_clk_in);
        rst_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        `CHK(ctrl_regs_out[12], 16'h0000)
        `CHK(sync_out_pin_out, 1'b1)
        chk_ctrl();
        $display("test reset done");
        for (int i = 0; i < 13; i++)
            acc(i, i == 12 ? 16'hffff : 16'($urandom), 1'b1, coin());
        for (int i = 0; i < 13; i++)
            acc(i, '0, 1'b0, coin());
        chk_ctrl();
        $display("test control done");
        for (int j = 0; j < 6; j++)
        begin
            a = j == 0 ? 13 : j == 1 ? 127 : 13 + $urandom % 115;
            acc(a, 16'($urandom), 1'b1, coin());
            acc(a, '0, 1'b0, coin());
        end
        chk_ctrl();
        $display("test unmapped done");
        for (int j = 0; j < 10; j++)
        begin
            a = j < 4 ? 128 + j * 42 + (j == 3 ? 1 : 0) : 128 + $urandom % 128;
            acc(a, 16'($urandom), 1'b1, coin());
            acc(a, '0, 1'b0, coin());
        end
        $display("test coefficients done");
        for (int j = 0; j < 4; j++)
        begin
            a = j == 0 ? 0 : j == 1 ? 255 : $urandom % 256;
            @(negedge core_clk_in);
            snap_write_in = 1'b1;
            snap_index_in = 8'(a);
            snap_data_in = 16'($urandom);
            exp_snap[a] = snap_data_in;
            @(negedge core_clk_in);
            snap_write_in = 1'b0;
            acc(256 + a, '0, 1'b0, coin());
            acc(256 + a, ~exp_snap[a], 1'b1, 1'b0);
            acc(256 + a, '0, 1'b0, coin());
        end
        $display("test snapshot done");
        for (int k = 0; k < 8; k++)
        begin
            acc(6, {15'($urandom), k[0]}, 1'b1, 1'b0);
            pulse_hi = 0;
            sync_lo = 0;
            acc(11, 16'($urandom), k[1], k[2]);
            `CHK(pulse_hi, 1)
            `CHK(sync_lo, int'(k[0]))
        end
        chk_ctrl();
        $display("test pulse done");
        stop_test();
    end
endmodule // filter_chip_host_control_port_tb
`default_nettype wire

// ### verilog/fchp_coef_store.sv
// Purpose: coefficient and snapshot word storage
// Assumes: one write port, one registered read port
// Notes: the snapshot area is written by capture logic outside
`default_nettype none
`include "fchp_map.svh"
module fchp_coef_store
    import fchp_pkg::*;
#(
    parameter int DEPTH = `FCHP_COEF_COUNT
)
(
    // Clock
    input wire logic core_clk_in,
    // Write port
    input wire logic write_in,
    input wire logic [$clog2(DEPTH)-1:0] write_index_in,
    input fchp_pkg::fchp_word_type write_data_in,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] read_index_in,
    output fchp_pkg::fchp_word_type read_data_out
);
    fchp_word_type mem [DEPTH];
    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("fchp_coef_store: DEPTH must be a power of two");
    end
    // No reset on the array so it maps onto plain RAM
    always_ff @(posedge core_clk_in)
    begin
        if (write_in)
            mem[write_index_in] <= write_data_in;
        read_data_out <= mem[read_index_in];
    end
endmodule // fchp_coef_store
`default_nettype wire

// ### verilog/fchp_host_port.sv
// Purpose: host control port of the dual-path filter device
// Assumes: host pins are asynchronous; sampled by two flops
// Notes: writes land while both strobes stay low; reads are registered
`default_nettype none
`include "fchp_map.svh"
// Operation
// [RL1] 16-bit two-way data bus, 9-bit address, active-low select/read/write.
// [RL2] Decode a 512-word space of control, coefficient and snapshot words.
// [RL3] Each control register is 16 bits, writable and readable. The code does not store writes to address 11.
// [RL4] Thirteen control registers sit at word addresses 0 to 12.
// [RL5] 128 coefficient registers at addresses 128 to 255, read and write.
// [RL6] Cell K owns coefficient addresses 128+4K to 128+4K+3.
// [RL7] Cells 0-15 belong to path A, cells 16-31 to path B.
// [RL8] Snapshot words at addresses 256 to 511 are host readable.
// [RL9] Any access to address 11 fires the single_pulse strobe.
// [RL10] single_pulse lasts one clock and may drive the sync output pin.
// [RL11] Addressed register loads while write and select are low.
// [RL12] Host writes: address, select, data, then a low write pulse.
// [RL13] Drive data only with select and read low and write high.
// [RL14] Data bus released when select high, read high or write low.
// [RL15] Host reads: address, select, lower read, sample, raise both.
// [RL16] Read tied low: write pin is direction, select is the strobe.
// [RL17] Host keeps write data stable through the whole write strobe.
// [RL18] Address 12 register clears to zero at power up.
// [RL19] Legacy: direction high is read, low is write, strobe low.
// [RL20] Addresses 13 to 127 read zero and ignore writes.
module fchp_host_port
    import fchp_pkg::*;
#(
    parameter int CTRL_COUNT = `FCHP_CTRL_COUNT
)
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Host pins
    input fchp_pkg::fchp_addr_type host_addr_in,
    input fchp_pkg::fchp_strobe_type host_strobe_in,
    input fchp_pkg::fchp_word_type host_data_in,
    output fchp_pkg::fchp_word_type host_data_out,
    output logic host_data_oe_out,
    // Snapshot capture side
    input wire logic snap_write_in,
    input wire logic [7:0] snap_index_in,
    input fchp_pkg::fchp_word_type snap_data_in,
    // Device side
    output fchp_pkg::fchp_word_type [CTRL_COUNT-1:0] ctrl_regs_out,
    output logic single_pulse_out,
    output logic sync_out_pin_out,
    output logic coef_path_b_out
);
    import fchp_pkg::*;

    localparam int PIN_W = `FCHP_ADDR_W + `FCHP_DATA_W + 3;

    typedef struct packed {
        fchp_word_type [CTRL_COUNT-1:0] ctrl;
        fchp_access_type prev;
        logic pulse;
        fchp_region_type rd_region;
        fchp_word_type rd_ctrl;
        logic path_b;
    } fchp_state_type;

    fchp_state_type state;
    fchp_state_type next_state;
    logic [PIN_W-1:0] pins_sync;
    fchp_addr_type addr;
    fchp_strobe_type strb;
    fchp_word_type wdata;
    fchp_access_type access;
    fchp_region_type region;
    fchp_word_type coef_rd;
    fchp_word_type snap_rd;
    fchp_word_type rd_word;
    logic legacy;
    logic coef_we;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    initial
    begin
        if (CTRL_COUNT != `FCHP_CTRL_COUNT)
            $error("fchp_host_port: CTRL_COUNT must be 13");
    end

    function automatic fchp_region_type region_of(input fchp_addr_type a);
        if (a >= `FCHP_SNAP_BASE)
            region_of = FCHP_REGION_SNAP; // RL8
        else if (a >= `FCHP_COEF_BASE)
            region_of = FCHP_REGION_COEF; // RL5
        else if (a <= `FCHP_CTRL_LAST)
            region_of = FCHP_REGION_CTRL; // RL4
        else
            region_of = FCHP_REGION_NONE; // RL20
    endfunction

    fchp_pin_sync #(
        .WIDTH(PIN_W)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .async_in({host_addr_in, host_strobe_in, host_data_in}),
        .reset_value_in('1),
        .sync_out(pins_sync)
    );
    assign {addr, strb, wdata} = pins_sync;

    // Tied-low read strobe selects the two-strobe legacy mode, except while select and write are both low
    assign legacy = !strb.output_enable_n && !strb.chip_select_n
        && !strb.write_strobe_n ? 1'b0 : !strb.output_enable_n; // RL16

    // A real legacy read also has output_enable_n low, so classification
    // is by select, the write pin and the read pin, which serves both modes
    always_comb
    begin
        if (strb.chip_select_n)
            access = FCHP_IDLE;
        else if (!strb.write_strobe_n)
            access = FCHP_WRITE; // RL11 RL19
        else if (!strb.output_enable_n)
            access = FCHP_READ; // RL13 RL19
        else
            access = FCHP_IDLE;
    end

    assign region = region_of(addr); // RL2
    assign coef_we = access == FCHP_WRITE
        && region == FCHP_REGION_COEF; // RL5 RL11

    fchp_coef_store #(
        .DEPTH(`FCHP_COEF_COUNT)
    ) u_coef (
        .core_clk_in(core_clk_in),
        .write_in(coef_we),
        .write_index_in(addr[6:0]),
        .write_data_in(wdata),
        .read_index_in(addr[6:0]),
        .read_data_out(coef_rd)
    );

    fchp_coef_store #(
        .DEPTH(`FCHP_SNAP_COUNT)
    ) u_snap (
        .core_clk_in(core_clk_in),
        .write_in(snap_write_in),
        .write_index_in(snap_index_in),
        .write_data_in(snap_data_in),
        .read_index_in(addr[7:0]),
        .read_data_out(snap_rd)
    );

    always_comb
    begin
        next_state = state;
        next_state.prev = access;
        // Level-sensitive load: data follows the pins while strobes are low
        if (access == FCHP_WRITE && region == FCHP_REGION_CTRL
            && addr != `FCHP_PULSE_ADDR)
            next_state.ctrl[addr[3:0]] = wdata; // RL3 RL11
        // One pulse per access, taken on the access's first cycle
        next_state.pulse = access != FCHP_IDLE && state.prev == FCHP_IDLE
            && addr == `FCHP_PULSE_ADDR; // RL9 RL10
        next_state.rd_region = region;
        if (region == FCHP_REGION_CTRL)
            next_state.rd_ctrl = state.ctrl[addr[3:0]]; // RL3
        else
            next_state.rd_ctrl = `FCHP_ZERO_WORD;
        // Cell index is addr[6:2]; its top bit picks the path
        next_state.path_b = addr[6:2] >= `FCHP_PATH_B_CELL; // RL6 RL7
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= '0; // RL18
            state.prev <= FCHP_IDLE;
            state.rd_region <= FCHP_REGION_CTRL;
        end
        else
            state <= next_state;
    end

    always_comb
    begin
        case (state.rd_region)
            FCHP_REGION_CTRL: rd_word = state.rd_ctrl;
            FCHP_REGION_COEF: rd_word = coef_rd;
            FCHP_REGION_SNAP: rd_word = snap_rd; // RL8
            FCHP_REGION_NONE: rd_word = `FCHP_ZERO_WORD; // RL20
            default: rd_word = `FCHP_ZERO_WORD;
        endcase
    end

    assign host_data_out = rd_word;
    // Enable straight from the raw pins so the bus turns off at once
    assign host_data_oe_out = !host_strobe_in.chip_select_n
        && !host_strobe_in.output_enable_n
        && host_strobe_in.write_strobe_n; // RL13 RL14 RL1
    assign ctrl_regs_out = state.ctrl;
    assign single_pulse_out = state.pulse;
    // Sync select bit in the counter/output register area: use reg 6 bit 0
    assign sync_out_pin_out = state.ctrl[`FCHP_SYNC_SEL_REG][`FCHP_SYNC_SEL_LSB]
        ? !state.pulse : 1'b1; // RL10
    assign coef_path_b_out = state.path_b; // RL7

    // Pulse and sync pin checks
    pulse_one_a: assert property ( // RL10
        single_pulse_out |=> !single_pulse_out)
        else $error("single pulse longer than one cycle");

    pulse_cause_a: assert property ( // RL9
        $rose(single_pulse_out) |-> $past(addr) == `FCHP_PULSE_ADDR
        && $past(access) != FCHP_IDLE)
        else $error("single pulse without access to address 11");

    pulse_first_a: assert property ( // RL9
        access != FCHP_IDLE && state.prev != FCHP_IDLE |=> !single_pulse_out)
        else $error("single pulse repeated within one access");

    pulse_store_a: assert property ( // RL9
        access == FCHP_WRITE && addr == `FCHP_PULSE_ADDR
        |=> $stable(ctrl_regs_out))
        else $error("write to the pulse address stored data");

    sync_idle_a: assert property ( // RL10
        !single_pulse_out |-> sync_out_pin_out)
        else $error("sync pin low without a pulse");

    sync_pulse_a: assert property ( // RL10
        single_pulse_out
        && ctrl_regs_out[`FCHP_SYNC_SEL_REG][`FCHP_SYNC_SEL_LSB]
        |-> !sync_out_pin_out)
        else $error("selected pulse missing on the sync pin");

    // Data bus drive checks
    oe_drive_a: assert property ( // RL13
        host_data_oe_out |-> host_strobe_in.write_strobe_n
        && !host_strobe_in.chip_select_n)
        else $error("data driven outside a read");

    oe_release_a: assert property ( // RL14
        host_strobe_in.output_enable_n |-> !host_data_oe_out)
        else $error("data driven with read strobe high");

    oe_write_a: assert property ( // RL14
        !host_strobe_in.write_strobe_n |-> !host_data_oe_out)
        else $error("data driven while write strobe low");

    oe_select_a: assert property ( // RL14
        host_strobe_in.chip_select_n |-> !host_data_oe_out)
        else $error("data driven while deselected");

    // Register map checks
    ctrl_load_a: assert property ( // RL11
        access == FCHP_WRITE && region == FCHP_REGION_CTRL
        && addr != `FCHP_PULSE_ADDR
        |=> ctrl_regs_out[$past(addr[3:0])] == $past(wdata))
        else $error("control register missed a write");

    ctrl_hold_a: assert property ( // RL11
        access != FCHP_WRITE |=> $stable(ctrl_regs_out))
        else $error("control register changed without write");

    ctrl_read_a: assert property ( // RL3
        access == FCHP_READ && region == FCHP_REGION_CTRL
        |=> host_data_out == $past(ctrl_regs_out[addr[3:0]]))
        else $error("control register read back wrong");

    unmapped_zero_a: assert property ( // RL20
        region == FCHP_REGION_NONE |=> host_data_out == `FCHP_ZERO_WORD)
        else $error("unmapped address read nonzero");

    unmapped_keep_a: assert property ( // RL20
        access == FCHP_WRITE && region == FCHP_REGION_NONE
        |=> $stable(ctrl_regs_out))
        else $error("unmapped write changed a register");

    coef_region_a: assert property ( // RL5
        coef_we |-> region == FCHP_REGION_COEF
        && !strb.chip_select_n && !strb.write_strobe_n)
        else $error("coefficient write outside its window");

    snap_nowrite_a: assert property ( // RL8
        region == FCHP_REGION_SNAP |-> !coef_we)
        else $error("host write reached coefficient store");

    region_top_a: assert property ( // RL2
        addr >= `FCHP_SNAP_BASE |-> region == FCHP_REGION_SNAP)
        else $error("upper half not decoded as snapshot");

    region_ctrl_a: assert property ( // RL4
        addr <= `FCHP_CTRL_LAST |-> region == FCHP_REGION_CTRL)
        else $error("control address not decoded");

    path_split_a: assert property ( // RL7
        1'b1 |=> coef_path_b_out == $past(addr[6]))
        else $error("coefficient path selection wrong");

    // Main scenarios
    write_cov: cover property (access == FCHP_WRITE);
    read_cov: cover property (host_data_oe_out);
    pulse_cov: cover property (single_pulse_out);
    legacy_cov: cover property (legacy);
    ext_write_cov: cover property (access == FCHP_WRITE
        && addr == `FCHP_EXT_ADDR);
endmodule // fchp_host_port
`default_nettype wire

// ### verilog/fchp_map.svh
// Purpose: address map and field constants of the host control port
// Assumes: word addresses on a 9-bit host address bus
// Notes: included by the package and the design modules
`ifndef FCHP_MAP_SVH
`define FCHP_MAP_SVH
`define FCHP_ADDR_W 9
`define FCHP_DATA_W 16
`define FCHP_CTRL_COUNT 13
`define FCHP_CTRL_LAST 9'h00c
`define FCHP_PULSE_ADDR 9'h00b
`define FCHP_EXT_ADDR 9'h00c
`define FCHP_COEF_BASE 9'h080
`define FCHP_COEF_LAST 9'h0ff
`define FCHP_SNAP_BASE 9'h100
`define FCHP_SNAP_LAST 9'h1ff
`define FCHP_COEF_COUNT 128
`define FCHP_PATH_B_CELL 5'h10
`define FCHP_SYNC_SEL_LSB 0
`define FCHP_SYNC_SEL_REG 4'h6
`define FCHP_SNAP_COUNT 256
`define FCHP_ZERO_WORD 16'h0000
`endif

// ### verilog/fchp_pin_sync.sv
// Purpose: two-flop synchroniser for the host pins
// Assumes: pins are asynchronous to core_clk_in
// Notes: strobes reset to their inactive (high) level
`default_nettype none
`include "fchp_map.svh"
module fchp_pin_sync
#(
    parameter int WIDTH = 28
)
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Pins
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_value_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } fchp_sync_state_type;
    fchp_sync_state_type state;
    fchp_sync_state_type next_state;
    initial
    begin
        if (WIDTH < 1)
            $error("fchp_pin_sync: WIDTH must be positive");
    end
    always_comb
    begin
        next_state.first = async_in;
        next_state.second = state.first;
    end
    // Reset value is all ones; reset_value_in is not used at all
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            state <= '1;
        else
            state <= next_state;
    end
    assign sync_out = state.second;
endmodule // fchp_pin_sync
`default_nettype wire

// ### verilog/fchp_pkg.sv
// Purpose: shared types of the host control port
// Assumes: fchp_map.svh holds the numbers
// Notes: strobe groups travel as packed structs
`default_nettype none
`include "fchp_map.svh"
package fchp_pkg;
    typedef logic [`FCHP_ADDR_W-1:0] fchp_addr_type;
    typedef logic [`FCHP_DATA_W-1:0] fchp_word_type;
    typedef struct packed {
        logic chip_select_n;
        logic output_enable_n;
        logic write_strobe_n;
    } fchp_strobe_type;
    typedef enum logic [1:0] {
        FCHP_IDLE = 2'b00,
        FCHP_WRITE = 2'b01,
        FCHP_READ = 2'b10
    } fchp_access_type;
    typedef enum logic [1:0] {
        FCHP_REGION_CTRL = 2'b00,
        FCHP_REGION_NONE = 2'b01,
        FCHP_REGION_COEF = 2'b10,
        FCHP_REGION_SNAP = 2'b11
    } fchp_region_type;
endpackage : fchp_pkg
`default_nettype wire
